// File: pkg/radio_spi_pkg.sv
/*
  Package for the radio link serial master: register addresses, field
  positions, reset values, timing limits and the packed carriers.
  Assumes an 8-bit special-function-register bus with one-cycle strobes.
*/
`default_nettype none
package radio_spi_pkg;
  // Register addresses on the special-function-register bus
  localparam logic [7:0] CFG_ADDR  = 8'h84;
  localparam logic [7:0] CTRL_ADDR = 8'hb0;
  localparam logic [7:0] DIV_ADDR  = 8'h85;
  localparam logic [7:0] DATA_ADDR = 8'h86;
  // Configuration fields
  localparam int CFG_BUSY_BIT  = 7;
  localparam int CFG_MASTER_BIT = 6;
  localparam int CFG_PHASE_BIT = 5;
  localparam int CFG_POL_BIT   = 4;
  // Control fields
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_WCOL_BIT = 6;
  localparam int CTRL_MODF_BIT = 5;
  localparam int CTRL_RSVD_BIT = 4;
  localparam int CTRL_SSM_HI   = 3;
  localparam int CTRL_SSM_LO   = 2;
  localparam int CTRL_TXE_BIT  = 1;
  localparam int CTRL_EN_BIT   = 0;
  localparam logic [1:0] SSM_FAULT = 2'h1;
  // Reset values
  localparam logic [1:0] SSM_RESET = 2'h1;
  localparam logic [7:0] DIV_RESET = 8'h00;
  // Timing figures
  localparam int SYS_CLK_HZ      = 100_000_000;
  localparam int SCK_MAX_HZ      = 12_500_000;
  localparam int MIN_HALF_CYCLES =
    (SYS_CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
  localparam int BITS_PER_BYTE = 8;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Serial pins toward the radio
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso_oe;
  } spi_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b10
  } shift_state_t;
endpackage
`default_nettype wire

// File: rtl/half_bit_timer.sv
/*
  Half-bit timer: pulses tick each time a half period has elapsed while run is high.
  Assumes the caller holds run low between transfers to restart it.
*/
`timescale 1ns/1ps
`default_nettype none
module half_bit_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  tick,
  output logic                  early
);
  logic [WIDTH-1:0] count;

  // Counts 0..limit, one half period is limit+1 cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (!run || tick) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick  = run && (count == limit);
  // One cycle ahead of tick; never fires for a zero limit
  assign early = run && (limit != '0) && (count == (limit - 1'b1));
endmodule
`default_nettype wire

// File: rtl/radio_link_spi_master.sv
/*
  Three-wire serial master toward the integrated radio, with its
  configuration, control, divider and data registers on the core's
  special-function-register bus. Assumes chip select is a separate port
  pin and that the bus gives one-cycle write and read strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module radio_link_spi_master #(
  parameter int DIV_WIDTH = 8
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire radio_spi_pkg::sfr_req_t sfr_req,
  output logic [7:0]                   sfr_rdata,
  input  wire logic                    miso,
  input  wire logic                    slave_select_n,
  output radio_spi_pkg::spi_pins_t     spi_pins,
  output logic                         spi_irq
);
  import radio_spi_pkg::*;

  logic [1:0]           miso_sync;
  logic [1:0]           nss_sync;
  logic                 master_enable;
  logic                 clock_phase;
  logic                 clock_polarity;
  logic                 done_flag;
  logic                 wcol_flag;
  logic                 modf_flag;
  logic                 rsvd_bit;
  logic [1:0]           slave_select_mode;
  logic                 port_enable;
  logic [7:0]           serial_clock_divider;
  logic [7:0]           tx_buffer;
  logic                 tx_full;
  logic [7:0]           shift_reg;
  logic [7:0]           rx_buffer;
  logic [3:0]           bit_count;
  shift_state_t         state;
  logic                 sampled;
  logic                 tick;
  logic                 early;
  logic [DIV_WIDTH-1:0] half_limit;
  logic                 busy;
  logic                 active;
  logic                 wr_cfg;
  logic                 wr_ctrl;
  logic                 wr_data;
  logic                 load;
  logic                 byte_end;
  logic                 fault;

  // Pins from the radio pass two flops before any logic looks at them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      miso_sync <= 2'h0;
      nss_sync  <= 2'h3;
    end else begin
      miso_sync <= {miso_sync[0], miso};
      nss_sync  <= {nss_sync[0], slave_select_n};
    end
  end

  // Address decode
  assign wr_cfg  = sfr_req.wr && (sfr_req.addr == CFG_ADDR);
  assign wr_ctrl = sfr_req.wr && (sfr_req.addr == CTRL_ADDR);
  assign wr_data = sfr_req.wr && (sfr_req.addr == DATA_ADDR);
  assign busy    = (state != ST_IDLE);
  assign active  = port_enable && master_enable;
  // Buffer moves to the shifter as soon as the shifter is free while port and master mode are both enabled
  assign load    = active && tx_full && !busy;
  assign fault   = !nss_sync[1] && master_enable
                   && (slave_select_mode == SSM_FAULT);

  // Divider floor keeps the rate legal even with a zero divider
  always_comb begin
    half_limit = DIV_WIDTH'(serial_clock_divider);
    if (32'(serial_clock_divider) + 1 < MIN_HALF_CYCLES) begin
      half_limit = DIV_WIDTH'(MIN_HALF_CYCLES - 1);
    end
  end

  half_bit_timer #(
    .WIDTH (DIV_WIDTH)
  ) half_bit_timer_inst (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (busy),
    .limit   (half_limit),
    .tick    (tick),
    .early   (early)
  );

  // Configuration register; a fault drops master mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      master_enable  <= 1'b0;
      clock_phase    <= 1'b0;
      clock_polarity <= 1'b0;
    end else if (fault) begin
      master_enable <= 1'b0;
    end else if (wr_cfg) begin
      master_enable  <= sfr_req.wdata[CFG_MASTER_BIT];
      clock_phase    <= sfr_req.wdata[CFG_PHASE_BIT];
      clock_polarity <= sfr_req.wdata[CFG_POL_BIT];
    end
  end

  // Control fields other than the flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_enable       <= 1'b0;
      slave_select_mode <= SSM_RESET;
      rsvd_bit          <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        slave_select_mode <= sfr_req.wdata[CTRL_SSM_HI:CTRL_SSM_LO];
        rsvd_bit          <= sfr_req.wdata[CTRL_RSVD_BIT];
        port_enable       <= sfr_req.wdata[CTRL_EN_BIT];
      end
      if (fault) begin
        port_enable <= 1'b0;
      end
    end
  end

  // Divider register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_clock_divider <= DIV_RESET;
    end else if (sfr_req.wr && (sfr_req.addr == DIV_ADDR)) begin
      serial_clock_divider <= sfr_req.wdata;
    end
  end

  // Sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_flag <= 1'b0;
      wcol_flag <= 1'b0;
      modf_flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        done_flag <= sfr_req.wdata[CTRL_DONE_BIT];
        wcol_flag <= sfr_req.wdata[CTRL_WCOL_BIT];
        modf_flag <= sfr_req.wdata[CTRL_MODF_BIT];
      end
      if (byte_end) begin
        done_flag <= 1'b1;
      end
      if (wr_data && tx_full) begin
        wcol_flag <= 1'b1;
      end
      if (fault) begin
        modf_flag <= 1'b1;
      end
    end
  end

  // Transmit buffer; a colliding write is dropped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_buffer <= 8'h00;
      tx_full   <= 1'b0;
    end else if (load) begin
      tx_full <= 1'b0;
    end else if (wr_data && !tx_full) begin
      tx_buffer <= sfr_req.wdata;
      tx_full   <= 1'b1;
    end
  end

  // Each bit is a lead half and a trail half; shift at the trail end in both phases
  assign byte_end = (state == ST_TRAIL) && tick && (bit_count == 4'(BITS_PER_BYTE - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      bit_count <= 4'h0;
      shift_reg <= 8'h00;
      sampled   <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          bit_count <= 4'h0;
          if (load) begin
            shift_reg <= tx_buffer;
            state     <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (!active) begin
            state <= ST_IDLE;
          end else if (tick) begin
            state <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          // Sample one cycle before the bit ends for slave settling
          if (early && !tick) begin
            sampled <= miso_sync[1];
          end
          if (tick && (half_limit == '0)) begin
            sampled <= miso_sync[1];
          end
          if (!active) begin
            state <= ST_IDLE;
          end else if (tick) begin
            shift_reg <= {shift_reg[6:0],
                          (half_limit == '0) ? miso_sync[1] : sampled};
            bit_count <= bit_count + 4'h1;
            state     <= byte_end ? ST_IDLE : ST_LEAD;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive buffer takes the finished byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_buffer <= 8'h00;
    end else if (byte_end) begin
      rx_buffer <= {shift_reg[6:0],
                    (half_limit == '0) ? miso_sync[1] : sampled};
    end
  end

  // Serial pins from flops; phase one toggles clock at bit start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spi_pins <= '0;
    end else begin
      spi_pins.miso_oe <= 1'b0;
      spi_pins.mosi    <= busy ? shift_reg[7] : 1'b0;
      if (!busy || !active) begin
        spi_pins.sck <= clock_polarity;
      end else if (clock_phase) begin
        spi_pins.sck <= clock_polarity ^ 1'b1;
        if (state == ST_TRAIL) begin
          spi_pins.sck <= clock_polarity;
        end
      end else begin
        spi_pins.sck <= clock_polarity ^ (state == ST_TRAIL);
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    sfr_rdata = 8'h00;
    case (sfr_req.addr)
      CFG_ADDR: begin
        sfr_rdata = {busy, master_enable, clock_phase, clock_polarity,
                     4'h0};
      end
      CTRL_ADDR: begin
        sfr_rdata = {done_flag, wcol_flag, modf_flag, rsvd_bit,
                     slave_select_mode, !tx_full, port_enable};
      end
      DIV_ADDR: begin
        sfr_rdata = serial_clock_divider;
      end
      DATA_ADDR: begin
        sfr_rdata = rx_buffer;
      end
      default: begin
        sfr_rdata = 8'h00;
      end
    endcase
  end

  assign spi_irq = done_flag || wcol_flag || modf_flag;

  busy_matches_a: assert property (@(posedge clk) disable iff (!reset_n)
    load |=> busy) else $error("busy missing after load");
  collide_sets_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_data && tx_full) |=> wcol_flag) else $error("collision lost");
  done_sets_a: assert property (@(posedge clk) disable iff (!reset_n)
    byte_end |=> done_flag) else $error("done lost");
  idle_clock_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!busy && $past(!busy) && $stable(clock_polarity)) |-> spi_pins.sck == clock_polarity)
    else $error("idle clock wrong");
  fault_drops_a: assert property (@(posedge clk) disable iff (!reset_n)
    fault |=> (modf_flag && !master_enable)) else $error("fault ignored");
  txe_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    load |=> !tx_full) else $error("buffer stays full");
  low_nibble_a: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.addr == CFG_ADDR) |-> sfr_rdata[3:0] == 4'h0)
    else $error("nibble not zero");
  disabled_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !active |=> !busy) else $error("transfer while disabled");
  miso_sample_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state == ST_TRAIL && tick) |-> $past(early))
    else $error("sample point late");
endmodule
`default_nettype wire

// File: tb/radio_slave_model.sv
/*
  Behavioural radio serial slave: mode zero, MSB first, full duplex.
  Assumes the bench drives its chip select as a separate port pin.
*/
`timescale 1ns/1ps
`default_nettype none
module radio_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       select_n,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] out_sr;
  logic       fresh = 1'b1;
  // Capture on the rising clock edge, MSB first
  always @(posedge sck) begin
    if (!select_n) got <= {got[6:0], mosi};
  end
  // One process owns the reply: load on select, next bit on falling edge
  always @(negedge sck or select_n) begin
    if (select_n) begin
      fresh <= 1'b1;
    end else if (fresh) begin
      out_sr <= reply;
      fresh  <= 1'b0;
    end else begin
      out_sr <= {out_sr[6:0], 1'b1};
    end
  end
  // Pull-up takes the line when deselected
  assign miso = select_n ? 1'b1 : out_sr[7];
endmodule
`default_nettype wire

// File: tb/radio_link_spi_master_tb_top.sv
/*
  Self-checking bench for the radio serial master.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module radio_link_spi_master_tb_top;
  import radio_spi_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       select_n = 1'b1;
  logic       slave_select_n = 1'b1;
  logic       miso;
  logic       irq;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [7:0] reply = 8'h00;
  sfr_req_t   req = '0;
  spi_pins_t  pins;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rises = 0;
  int last_rise = 0;
  int period = 0;

  always #5 clk = ~clk;

  radio_link_spi_master #(.DIV_WIDTH(8)) radio_link_spi_master_inst (
    .clk(clk), .reset_n(reset_n), .sfr_req(req), .sfr_rdata(rdata),
    .miso(miso), .slave_select_n(slave_select_n), .spi_pins(pins),
    .spi_irq(irq));
  radio_slave_model radio_slave_model_inst (
    .sck(pins.sck), .mosi(pins.mosi), .select_n(select_n),
    .reply(reply), .miso(miso), .got(got));

  // Cycle count and hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // Serial clock period in system cycles
  always @(posedge pins.sck) begin
    period = cycles - last_rise;
    last_rise = cycles;
    rises++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    @(negedge clk);
    d = rdata;
  endtask
  // Poll busy under a bound so a stuck transfer cannot hang the run
  task automatic wait_idle();
    logic [7:0] v;
    int n;
    n = 0;
    rd(CFG_ADDR, v);
    while (v[7] !== 1'b0 && n < 500) begin
      rd(CFG_ADDR, v);
      n++;
    end
    check(8'(n < 500), 8'h01);
  endtask
  task automatic stop_test();
    $display("checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_reset();
    logic [7:0] v;
    rd(CFG_ADDR, v);  check(v, 8'h00);
    rd(CTRL_ADDR, v); check(v, 8'h06);
    rd(DIV_ADDR, v);  check(v, 8'h00);
    check({7'h0, pins.sck}, 8'h00);
    check({7'h0, pins.miso_oe}, 8'h00);
    wr(CFG_ADDR, 8'hff);
    rd(CFG_ADDR, v);  check(v, 8'h70);
    check({7'h0, pins.sck}, 8'h01);
    wr(CFG_ADDR, 8'h00);
    rd(CFG_ADDR, v);  check({7'h0, pins.sck}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_xfer(input logic [7:0] dv, input logic [7:0] d,
                        input logic [7:0] rp);
    logic [7:0] v;
    int r0;
    wr(CTRL_ADDR, 8'h01); // Reserved bit and select mode written zero
    wr(CFG_ADDR, 8'h40);  // Master, polarity and phase zero
    wr(DIV_ADDR, dv);
    // Reply settles before the select edge that loads it
    reply <= rp;
    @(posedge clk);
    select_n <= 1'b0;
    r0 = rises;
    wr(DATA_ADDR, d);
    rd(CFG_ADDR, v);  check(v & 8'h80, 8'h80);
    rd(CTRL_ADDR, v); check(v & 8'h02, 8'h02);
    wait_idle();
    check(got, d);
    rd(DATA_ADDR, v); check(v, rp);
    rd(CTRL_ADDR, v); check(v & 8'he0, 8'h80);
    check({7'h0, irq}, 8'h01);
    check(8'(rises - r0), 8'h08);
    check(8'(period), 8'(2 * ((dv + 1 > 4) ? dv + 1 : 4)));
    wr(CTRL_ADDR, 8'h01);
    rd(CTRL_ADDR, v); check(v & 8'he0, 8'h00);
    @(posedge clk);
    select_n <= 1'b1;
    $display("test transfer done");
  endtask
  task automatic t_collision();
    logic [7:0] v;
    @(posedge clk);
    select_n <= 1'b0;
    wr(DATA_ADDR, 8'h11);
    wr(DATA_ADDR, 8'h22);
    rd(CTRL_ADDR, v); check(v, 8'h01);
    wr(DATA_ADDR, 8'h33);
    rd(CTRL_ADDR, v); check(v & 8'h40, 8'h40);
    check({7'h0, irq}, 8'h01);
    // Busy drops for one cycle between the two bytes
    wait_idle();
    check(got, 8'h11);
    wait_idle();
    check(got, 8'h22);
    wr(CTRL_ADDR, 8'h01);
    rd(CTRL_ADDR, v); check(v & 8'he0, 8'h00);
    @(posedge clk);
    select_n <= 1'b1;
    $display("test collision done");
  endtask
  // Second-edge phase: eight clock pulses, rate floor, idle level kept
  task automatic t_phase();
    logic [7:0] v;
    int r0;
    wr(CFG_ADDR, 8'h60);
    r0 = rises;
    wr(DATA_ADDR, 8'h96);
    wait_idle();
    check(8'(rises - r0), 8'h08);
    check(8'(period), 8'(2 * MIN_HALF_CYCLES));
    check({7'h0, pins.sck}, 8'h00);
    rd(CTRL_ADDR, v); check(v & 8'he0, 8'h80);
    wr(CTRL_ADDR, 8'h01);
    wr(CFG_ADDR, 8'h40);
    $display("test phase done");
  endtask
  task automatic t_fault();
    logic [7:0] v;
    wr(CTRL_ADDR, 8'h05);
    wr(CFG_ADDR, 8'h40);
    @(posedge clk);
    slave_select_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd(CTRL_ADDR, v); check(v & 8'h21, 8'h20);
    check({7'h0, irq}, 8'h01);
    rd(CFG_ADDR, v);  check(v & 8'h40, 8'h00);
    @(posedge clk);
    slave_select_n <= 1'b1;
    wr(CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, v); check(v & 8'he0, 8'h00);
    $display("test fault done");
  endtask
  task automatic t_disable();
    logic [7:0] v;
    int r0;
    wr(CFG_ADDR, 8'h40);
    r0 = rises;
    wr(DATA_ADDR, 8'h77);
    repeat (100) @(posedge clk);
    check(8'(rises - r0), 8'h00);
    rd(CFG_ADDR, v); check(v & 8'h80, 8'h00);
    $display("test disable done");
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_xfer(8'h04, 8'ha5, 8'h3c);
    t_xfer(8'h00, 8'h5a, 8'hc3);
    t_collision();
    t_phase();
    t_fault();
    t_disable();
    stop_test();
  end
endmodule
`default_nettype wire
